// >>> hw/pmta_pkg.sv
// Purpose: shared constants and carriers for program memory table access
// Assumes: one core clock, flash read data valid one cycle after strobe
// Notes: register select codes address the special function space port
// Notes on behaviour
// RQ1 - Eight-bit table latch in special function space
// RQ2 - Three pointer bytes join into 22-bit pointer
// RQ3 - Low 21 pointer bits address 2 Mbytes
// RQ4 - Top pointer bit selects identification/configuration space
// RQ5 - Four pointer modes: hold, postinc, postdec, preinc
// RQ6 - Pointer stepping touches only low 21 bits
// RQ7 - Table read uses full pointer, loads latch
// RQ8 - Table write: pointer bits 2:0 pick holding register
// RQ9 - Long write start: bits 21:3 pick block
// RQ10 - Erase: bits 21:6 pick block, 5:0 ignored
// RQ11 - Stepping wraps modulo 2^21, no top carry
package pmta_pkg;

  localparam int PTR_W = 22;
  localparam int LOW_W = 21;
  localparam int BYTE_W = 8;
  localparam int HOLD_SEL_W = 3;
  localparam int WBLK_LSB = 3;
  localparam int EBLK_LSB = 6;
  localparam int WBLK_W = PTR_W - WBLK_LSB;
  localparam int EBLK_W = PTR_W - EBLK_LSB;
  localparam int CFG_BIT = 21;

  localparam logic [BYTE_W-1:0] LATCH_RST = 8'h00;
  localparam logic [PTR_W-1:0] PTR_RST = 22'h00_0000;
  localparam logic [LOW_W-1:0] LOW_ONE = 21'h00_0001;

  // Register select codes on the special function space port
  localparam logic [1:0] SEL_LATCH = 2'h0;
  localparam logic [1:0] SEL_PTR_LOW = 2'h1;
  localparam logic [1:0] SEL_PTR_HIGH = 2'h2;
  localparam logic [1:0] SEL_PTR_UPPER = 2'h3;

  typedef enum logic [1:0] {
    MODE_HOLD = 2'h0,
    MODE_POST_INC = 2'h1,
    MODE_POST_DEC = 2'h2,
    MODE_PRE_INC = 2'h3
  } pmta_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_DATA = 2'h3
  } pmta_state_type;

  typedef struct packed {
    logic valid;
    logic is_write;
    pmta_mode_type mode;
  } pmta_op_req_type;

  typedef struct packed {
    logic we;
    logic [1:0] sel;
    logic [BYTE_W-1:0] data;
  } pmta_sfr_wr_type;

  typedef struct packed {
    logic en;
    logic cfg_space;
    logic [PTR_W-1:0] addr;
  } pmta_rd_req_type;

  typedef struct packed {
    logic we;
    logic [HOLD_SEL_W-1:0] sel;
    logic [BYTE_W-1:0] data;
  } pmta_hold_wr_type;

endpackage : pmta_pkg

// >>> hw/pmta_ptr_step.sv
// Purpose: pointer plus and minus one for table instructions
// Assumes: purely combinational, same clock as caller
// Notes: top bit passes through untouched
`timescale 1ns/1ns
module pmta_ptr_step (
  input wire logic [pmta_pkg::PTR_W-1:0] ptr,
  output logic [pmta_pkg::PTR_W-1:0] ptr_inc,
  output logic [pmta_pkg::PTR_W-1:0] ptr_dec
);
  import pmta_pkg::*;

  logic [LOW_W-1:0] low_inc;
  logic [LOW_W-1:0] low_dec;

  // Width-limited sum drops the carry, so the low field wraps
  always_comb begin
    low_inc = ptr[LOW_W-1:0] + LOW_ONE; // RQ11
    low_dec = ptr[LOW_W-1:0] - LOW_ONE; // RQ11
    ptr_inc = {ptr[CFG_BIT], low_inc}; // RQ6
    ptr_dec = {ptr[CFG_BIT], low_dec}; // RQ6
  end

endmodule : pmta_ptr_step

// >>> hw/pmta_table_access.sv
// Purpose: table pointer, table latch and address staging toward flash
// Assumes: core and flash logic share ref_clk; flash returns read byte
// Assumes: exactly one cycle after the read strobe
// Notes: special function space writes take priority over a new op
`timescale 1ns/1ns
module pmta_table_access (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire pmta_pkg::pmta_sfr_wr_type sfr_wr,
  input wire logic [1:0] sfr_rd_sel,
  output logic [pmta_pkg::BYTE_W-1:0] sfr_rd_data,
  input wire pmta_pkg::pmta_op_req_type op_req,
  output logic op_busy,
  output logic op_done,
  output pmta_pkg::pmta_rd_req_type rd_req,
  input wire logic [pmta_pkg::BYTE_W-1:0] rd_data,
  output pmta_pkg::pmta_hold_wr_type hold_wr,
  input wire logic long_write_start,
  output logic long_write_go,
  output logic [pmta_pkg::WBLK_W-1:0] long_write_block,
  input wire logic erase_start,
  output logic erase_go,
  output logic [pmta_pkg::EBLK_W-1:0] erase_block
);
  import pmta_pkg::*;

  pmta_state_type state;
  pmta_state_type next_state;
  logic [BYTE_W-1:0] table_data_latch;
  logic [BYTE_W-1:0] next_table_data_latch;
  logic [PTR_W-1:0] program_byte_pointer;
  logic [PTR_W-1:0] next_program_byte_pointer;
  logic op_is_write;
  logic next_op_is_write;
  pmta_mode_type op_mode;
  pmta_mode_type next_op_mode;
  logic next_op_busy;
  logic next_op_done;
  logic [BYTE_W-1:0] next_sfr_rd_data;
  pmta_rd_req_type next_rd_req;
  pmta_hold_wr_type next_hold_wr;
  logic next_long_write_go;
  logic [WBLK_W-1:0] next_long_write_block;
  logic next_erase_go;
  logic [EBLK_W-1:0] next_erase_block;
  logic [PTR_W-1:0] ptr_inc;
  logic [PTR_W-1:0] ptr_dec;
  logic [PTR_W-1:0] eff_ptr;

  // Byte views of the joined pointer
  logic [BYTE_W-1:0] pointer_upper_byte;
  logic [BYTE_W-1:0] pointer_high_byte;
  logic [BYTE_W-1:0] pointer_low_byte;

  // Upper byte holds only bits 21:16; bits 7:6 read as zero
  assign pointer_upper_byte = {2'h0, program_byte_pointer[PTR_W-1:2*BYTE_W]}; // RQ2
  assign pointer_high_byte = program_byte_pointer[2*BYTE_W-1:BYTE_W]; // RQ2
  assign pointer_low_byte = program_byte_pointer[BYTE_W-1:0]; // RQ2

  pmta_ptr_step u_step (
    .ptr(program_byte_pointer),
    .ptr_inc(ptr_inc),
    .ptr_dec(ptr_dec)
  );

  // Register read mux, one cycle of latency
  always_comb begin
    case (sfr_rd_sel)
      SEL_LATCH: next_sfr_rd_data = table_data_latch; // RQ1
      SEL_PTR_LOW: next_sfr_rd_data = pointer_low_byte;
      SEL_PTR_HIGH: next_sfr_rd_data = pointer_high_byte;
      SEL_PTR_UPPER: next_sfr_rd_data = pointer_upper_byte;
      default: next_sfr_rd_data = 8'h00;
    endcase
  end

  // Pre-increment picks the stepped pointer as the access address
  always_comb begin
    if (op_req.mode == MODE_PRE_INC) begin
      eff_ptr = ptr_inc; // RQ5
    end else begin
      eff_ptr = program_byte_pointer;
    end
  end

  // Sequencer, pointer and latch
  always_comb begin
    next_state = state;
    next_table_data_latch = table_data_latch;
    next_program_byte_pointer = program_byte_pointer;
    next_op_is_write = op_is_write;
    next_op_mode = op_mode;
    next_op_done = 1'b0;
    next_rd_req = '0;
    next_hold_wr = '0;
    case (state)
      ST_IDLE: begin
        // A register write wins; a pending op waits one more cycle
        if (sfr_wr.we) begin
          case (sfr_wr.sel)
            SEL_LATCH: next_table_data_latch = sfr_wr.data; // RQ1
            SEL_PTR_LOW: next_program_byte_pointer[BYTE_W-1:0] = sfr_wr.data; // RQ2
            SEL_PTR_HIGH: next_program_byte_pointer[2*BYTE_W-1:BYTE_W] = sfr_wr.data; // RQ2
            SEL_PTR_UPPER: begin
              // Only six bits exist above bit 15
              next_program_byte_pointer[PTR_W-1:2*BYTE_W] = sfr_wr.data[5:0]; // RQ2
            end
            default: next_program_byte_pointer = program_byte_pointer;
          endcase
        end else if (op_req.valid) begin
          next_program_byte_pointer = eff_ptr; // RQ5
          next_op_is_write = op_req.is_write;
          next_op_mode = op_req.mode;
          if (op_req.is_write) begin
            next_hold_wr.we = 1'b1;
            next_hold_wr.sel = eff_ptr[HOLD_SEL_W-1:0]; // RQ8
            next_hold_wr.data = table_data_latch; // RQ8
          end else begin
            next_rd_req.en = 1'b1;
            next_rd_req.addr = eff_ptr; // RQ7 RQ3
            next_rd_req.cfg_space = eff_ptr[CFG_BIT]; // RQ4
          end
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        next_state = ST_DATA;
      end
      ST_DATA: begin
        // Flash byte stands this cycle, one after the strobe
        if (!op_is_write) begin
          next_table_data_latch = rd_data; // RQ7
        end
        case (op_mode)
          MODE_POST_INC: next_program_byte_pointer = ptr_inc; // RQ5
          MODE_POST_DEC: next_program_byte_pointer = ptr_dec; // RQ5
          default: next_program_byte_pointer = program_byte_pointer; // RQ5
        endcase
        next_op_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    next_op_busy = (next_state != ST_IDLE);
  end

  // Long write block follows the pointer only at a start pulse
  always_comb begin
    next_long_write_go = long_write_start;
    next_long_write_block = long_write_block;
    if (long_write_start) begin
      next_long_write_block = program_byte_pointer[PTR_W-1:WBLK_LSB]; // RQ9
    end
  end

  // Erase block uses the pointer as it stood before any same-cycle write
  always_comb begin
    next_erase_go = erase_start;
    next_erase_block = erase_block;
    if (erase_start) begin
      // Low six bits are dropped, any byte in the block selects it
      next_erase_block = program_byte_pointer[PTR_W-1:EBLK_LSB]; // RQ10
    end
  end

  // Sequencer, pointer and latch registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      table_data_latch <= LATCH_RST;
      program_byte_pointer <= PTR_RST;
      op_is_write <= 1'b0;
      op_mode <= MODE_HOLD;
      op_busy <= 1'b0;
      op_done <= 1'b0;
    end else begin
      state <= next_state;
      table_data_latch <= next_table_data_latch;
      program_byte_pointer <= next_program_byte_pointer;
      op_is_write <= next_op_is_write;
      op_mode <= next_op_mode;
      op_busy <= next_op_busy;
      op_done <= next_op_done;
    end
  end

  // Flash strobes last one cycle; the next pass clears them
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_req <= '0;
      hold_wr <= '0;
    end else begin
      rd_req <= next_rd_req;
      hold_wr <= next_hold_wr;
    end
  end

  // Read-back register, one cycle behind the select
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sfr_rd_data <= LATCH_RST;
    end else begin
      sfr_rd_data <= next_sfr_rd_data;
    end
  end

  // Long write echo and block
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      long_write_go <= 1'b0;
      long_write_block <= '0;
    end else begin
      long_write_go <= next_long_write_go;
      long_write_block <= next_long_write_block;
    end
  end

  // Erase echo and block
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      erase_go <= 1'b0;
      erase_block <= '0;
    end else begin
      erase_go <= next_erase_go;
      erase_block <= next_erase_block;
    end
  end

endmodule : pmta_table_access

// >>> verification/pmta_table_access_properties.sv
// Purpose: port checks for table access staging
// Assumes: one clock, asynchronous low reset
// Notes: the pointer is internal, so stepping is judged by the bench
`timescale 1ns/1ns
module pmta_chk (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic op_busy,
  input wire logic op_done,
  input wire pmta_pkg::pmta_rd_req_type rd_req,
  input wire pmta_pkg::pmta_hold_wr_type hold_wr,
  input wire logic long_write_start,
  input wire logic long_write_go,
  input wire logic [pmta_pkg::WBLK_W-1:0] long_write_block,
  input wire logic erase_start,
  input wire logic erase_go,
  input wire logic [pmta_pkg::EBLK_W-1:0] erase_block
);
  import pmta_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_read_done: assert property (rd_req.en |-> op_busy ##1 op_busy ##1 op_done)
    else $error("read op late");
  a_write_done: assert property (hold_wr.we |-> op_busy ##1 op_busy ##1 op_done)
    else $error("write op late");
  a_busy_span: assert property ($rose(op_busy) |-> op_busy[*2] ##1 !op_busy)
    else $error("busy span wrong");
  a_cfg_route: assert property (rd_req.en |-> rd_req.cfg_space == rd_req.addr[CFG_BIT])
    else $error("space select wrong");
  a_lw_echo: assert property (long_write_start |=> long_write_go)
    else $error("no long write go");
  a_er_echo: assert property (erase_start |=> erase_go)
    else $error("no erase go");
  a_lw_hold: assert property (!long_write_go |-> $stable(long_write_block))
    else $error("write block moved");
  a_er_hold: assert property (!erase_go |-> $stable(erase_block))
    else $error("erase block moved");
  c_cfg_read: cover property (rd_req.en && rd_req.cfg_space);
  c_hold_write: cover property (hold_wr.we);
  c_erase: cover property (erase_go);
endmodule : pmta_chk
bind pmta_table_access pmta_chk i_pmta_chk (.ref_clk, .rst_b, .op_busy, .op_done,
  .rd_req, .hold_wr, .long_write_start, .long_write_go, .long_write_block,
  .erase_start, .erase_go, .erase_block);

// >>> verification/pmta_flash_model.sv
// Purpose: flash array stand-in answering read strobes
// Assumes: byte due one cycle after the strobe
// Notes: byte is a fixed function of the address
`timescale 1ns/1ns
module pmta_flash_model (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire pmta_pkg::pmta_rd_req_type rd_req,
  output logic [pmta_pkg::BYTE_W-1:0] rd_data
);
  // Idle cycles invert the byte so a late sample cannot pass
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= 8'h00;
    end else if (rd_req.en) begin
      rd_data <= rd_req.addr[7:0] ^ {rd_req.cfg_space, 7'h35};
    end else begin
      rd_data <= ~rd_data;
    end
  end
endmodule : pmta_flash_model

// >>> verification/tb.sv
// Purpose: directed bench for pointer, latch and flash staging
// Assumes: stimulus and checks on falling edges
// Notes: upper pointer byte is written with bits 7:6 set on purpose in the mode loop
`timescale 1ns/1ns
module tb;
  import pmta_pkg::*;
  logic ref_clk, rst_b, op_busy, op_done, long_write_start, long_write_go;
  logic erase_start, erase_go;
  logic [1:0] sfr_rd_sel;
  logic [7:0] sfr_rd_data, rd_data, v;
  logic [WBLK_W-1:0] long_write_block;
  logic [EBLK_W-1:0] erase_block;
  logic [23:0] p;
  logic [21:0] base, eff, fin;
  pmta_sfr_wr_type sfr_wr;
  pmta_op_req_type op_req;
  pmta_rd_req_type rd_req, rd_q;
  pmta_hold_wr_type hold_wr, hw_q;
  int fail_count = 0;
  int samples_checked = 0;
  pmta_table_access i_pmta_table_access (.ref_clk, .rst_b, .sfr_wr, .sfr_rd_sel,
    .sfr_rd_data, .op_req, .op_busy, .op_done, .rd_req, .rd_data, .hold_wr,
    .long_write_start, .long_write_go, .long_write_block, .erase_start, .erase_go,
    .erase_block);
  pmta_flash_model i_pmta_flash_model (.ref_clk, .rst_b, .rd_req, .rd_data);
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  task print_verdict;
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  task chk(input logic [23:0] g, input logic [23:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function logic [21:0] stp(input logic [21:0] a, input logic [20:0] d);
    return {a[21], a[20:0] + d};
  endfunction : stp
  task wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_wr = {1'b1, s, d};
    @(negedge ref_clk);
    sfr_wr = '0;
  endtask : wr
  task rd(input logic [1:0] s);
    @(negedge ref_clk);
    sfr_rd_sel = s;
    @(negedge ref_clk);
    v = sfr_rd_data;
  endtask : rd
  // Valid drops once busy shows; busy covers the next edge, so no double take
  task op(input logic w, input pmta_mode_type m);
    int i;
    @(negedge ref_clk);
    op_req = {1'b1, w, m};
    for (i = 0; i < 8 && op_busy !== 1'b1; i++) @(negedge ref_clk);
    rd_q = rd_req;
    hw_q = hold_wr;
    op_req = '0;
    for (i = i; i < 8 && op_done !== 1'b1; i++) @(negedge ref_clk);
    if (i == 8) begin
      fail_count++;
      print_verdict;
    end
  endtask : op
  initial begin
    rst_b = 0;
    sfr_wr = '0;
    sfr_rd_sel = 2'h0;
    op_req = '0;
    long_write_start = 0;
    erase_start = 0;
    repeat (16) @(negedge ref_clk);
    rst_b = 1;
    for (int s = 0; s < 4; s++) begin
      rd(2'(s));
      chk(v, '0);
    end
    // Third pass reads below the top bit, so a carry into it would show
    for (int w = 0; w < 3; w++) begin
      for (int m = 0; m < 4; m++) begin
        base = (w == 1) ? 22'h20_0000 : (w == 2) ? 22'h1F_FFFF : 22'h3F_FFFF;
        wr(SEL_LATCH, 8'hC6);
        wr(SEL_PTR_LOW, base[7:0]);
        wr(SEL_PTR_HIGH, base[15:8]);
        wr(SEL_PTR_UPPER, {2'h3, base[21:16]});
        op(w == 1, pmta_mode_type'(m));
        eff = (m == 3) ? stp(base, 21'h00_0001) : base;
        fin = (m[0]) ? stp(base, 21'h00_0001) : (m == 2) ? stp(base, 21'h1F_FFFF) : base;
        if (w == 1) begin
          chk(hw_q.we, 1'h1);
          chk(hw_q.sel, eff[2:0]);
          chk(hw_q.data, 8'hC6);
        end else begin
          chk(rd_q.en, 1'h1);
          chk(rd_q.addr, eff);
          chk(rd_q.cfg_space, eff[21]);
          rd(SEL_LATCH);
          chk(v, eff[7:0] ^ {eff[21], 7'h35});
        end
        rd(SEL_PTR_LOW);
        p[7:0] = v;
        rd(SEL_PTR_HIGH);
        p[15:8] = v;
        rd(SEL_PTR_UPPER);
        p[23:16] = v;
        chk(p, {2'h0, fin});
      end
    end
    wr(SEL_PTR_LOW, 8'hDE);
    wr(SEL_PTR_HIGH, 8'hBC);
    wr(SEL_PTR_UPPER, 8'h2A);
    @(negedge ref_clk);
    long_write_start = 1;
    erase_start = 1;
    @(negedge ref_clk);
    long_write_start = 0;
    erase_start = 0;
    chk(long_write_go, 1'h1);
    chk(long_write_block, 22'h2A_BCDE >> 3);
    chk(erase_go, 1'h1);
    chk(erase_block, 22'h2A_BCDE >> 6);
    print_verdict;
  end
endmodule : tb
